// >>> design/frwl_latch_bank.sv
`timescale 1ns/1ns
module frwl_latch_bank
  import frwl_pkg::*;
#(
  parameter int WORD_W  = FRWL_WORD_W,
  parameter int LATCHES = FRWL_LATCHES,
  parameter int AW      = FRWL_LATCH_AW
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Load and clear
  input  wire logic              load_i,
  input  wire logic [AW-1:0]     load_idx_i,
  input  wire logic [WORD_W-1:0] load_data_i,
  input  wire logic              clear_i,
  // Read port toward the array
  input  wire logic [AW-1:0]     rd_idx_i,
  output logic      [WORD_W-1:0] rd_data_o
);
  logic [WORD_W-1:0] lat_r   [LATCHES];
  logic [WORD_W-1:0] lat_nxt [LATCHES];

  always_comb
  begin
    for (int i = 0; i < LATCHES; i++)
    begin
      lat_nxt[i] = lat_r[i];
      // R07 blank after operation
      if (clear_i)
        lat_nxt[i] = WORD_W'(FRWL_BLANK);
      else if (load_i && load_idx_i == AW'(i))
        lat_nxt[i] = load_data_i;
    end
  end

  // R08 unloaded stay blank
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < LATCHES; i++)
        lat_r[i] <= FRWL_BLANK;
    end
    else
    begin
      for (int i = 0; i < LATCHES; i++)
        lat_r[i] <= lat_nxt[i];
    end
  end

  assign rd_data_o = lat_r[rd_idx_i];
endmodule

// >>> design/frwl_pkg.sv
package frwl_pkg;
  // APB byte addresses
  localparam logic [7:0] FRWL_ADDR_LOW_OFS  = 8'h00;
  localparam logic [7:0] FRWL_ADDR_HIGH_OFS = 8'h04;
  localparam logic [7:0] FRWL_DATA_LOW_OFS  = 8'h08;
  localparam logic [7:0] FRWL_DATA_HIGH_OFS = 8'h0C;
  localparam logic [7:0] FRWL_CONTROL_OFS   = 8'h10;
  localparam logic [7:0] FRWL_UNLOCK_OFS    = 8'h14;
  localparam logic [7:0] FRWL_STATUS_OFS    = 8'h18;
  // Control register fields
  localparam int FRWL_CTL_RD_BIT   = 0;
  localparam int FRWL_CTL_GO_BIT   = 1;
  localparam int FRWL_CTL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int FRWL_CTL_ERR_BIT  = 3;
  localparam int FRWL_CTL_LATCH_ONLY_SELECT_BIT = 5;
  localparam int FRWL_CTL_CONFIG_SPACE_SELECT_BIT = 6;
  localparam int FRWL_CTL_FREE_BIT = 4;
  // Unlock keys
  localparam logic [7:0] FRWL_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FRWL_KEY_SECOND = 8'hAA;
  // Array shape
  localparam int FRWL_WORD_W    = 14;
  localparam int FRWL_LATCH_AW  = 4;
  localparam int FRWL_ROW_AW    = 11;
  localparam int FRWL_LATCHES   = 16;
  localparam logic [13:0] FRWL_BLANK = 14'h3FFF;
  // Timing
  localparam int FRWL_CLK_MHZ     = 100;
  localparam int FRWL_PROG_US     = 2000;
  localparam int FRWL_PROG_CYCLES = FRWL_PROG_US * FRWL_CLK_MHZ;
  localparam int FRWL_NOP_CYCLES  = 2;
  typedef enum logic [2:0] {
    FRWL_IDLE,
    FRWL_NOPS,
    FRWL_ARRAY,
    FRWL_CLEAR
  } frwl_state_t;
endpackage

// >>> design/frwl_top.sv
// Notes on behaviour
// R01 - Software sets row address, fills latches, starts program, repeats.
// R02 - Program never erases; target words must already be blank.
// R03 - Erase works on exactly one row per operation.
// R04 - One program writes one to sixteen words, never more.
// R05 - Upper 11 address bits pick row; low 4 bits pick latch.
// R06 - Writes stay inside the addressed row.
// R07 - All latches return to 0x3FFF after each write or erase.
// R08 - Latches not loaded keep blank value for partial rows.
// R09 - Latch-only set: unlock copies data into selected latch only.
// R10 - Latch-only clear: unlock loads latch then programs whole row.
// R11 - Broken unlock sequence loads nothing and programs nothing.
// R12 - Software sets write enable, clears config select, sets latch-only.
// R13 - Software increments address per load, clears latch-only for last.
// R14 - Unlock is 55h then AAh to key register, then go bit.
// R15 - After go the core gets two forced no-operation cycles.
// R16 - Row erase or program stalls the core about 2 ms.
// R17 - Software should mask interrupts around the unlock sequence.
// R18 - Words are 14 bits: six high data bits plus low byte.
`timescale 1ns/1ns
module frwl_top
  import frwl_pkg::*;
#(
  parameter int PROG_CYCLES = FRWL_PROG_CYCLES,
  parameter int WORD_W      = FRWL_WORD_W,
  parameter int ROW_AW      = FRWL_ROW_AW,
  parameter int LATCH_AW    = FRWL_LATCH_AW
)
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Core stall
  output logic                            core_stall_o,
  // Flash array port
  output logic                            arr_prog_o,
  output logic                            arr_erase_o,
  output logic      [ROW_AW+LATCH_AW-1:0] arr_addr_o,
  output logic      [WORD_W-1:0]          arr_wdata_o,
  input  wire logic [WORD_W-1:0]          arr_rdata_i
);
  localparam int AW = ROW_AW + LATCH_AW;

  // Registers
  logic [7:0]  adr_lo_r, adr_lo_nxt;
  logic [7:0]  adr_hi_r, adr_hi_nxt;
  logic [7:0]  dat_lo_r, dat_lo_nxt;
  logic [7:0]  dat_hi_r, dat_hi_nxt;
  logic        write_enable_bit_r, write_enable_bit_nxt;
  logic        config_space_select_r, config_space_select_nxt;
  logic        latch_only_select_r, latch_only_select_nxt;
  logic        free_r, free_nxt;
  logic        err_r, err_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt;
  // Sequencer
  frwl_state_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [LATCH_AW-1:0] idx_r, idx_nxt;
  logic        stall_r, stall_nxt;
  logic        prog_r, prog_nxt;
  logic        erase_r, erase_nxt;
  logic [AW-1:0] aaddr_r, aaddr_nxt;
  logic [WORD_W-1:0] awd_r, awd_nxt;
  logic        op_erase_r, op_erase_nxt;

  logic access, wr, rd, busy;
  logic key_wr, go_set, other_wr, armed;
  logic lat_load, lat_clear;
  logic [WORD_W-1:0] lat_word, lat_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign access = psel && penable && pready;
  assign busy = (st_r != FRWL_IDLE);
  assign wr = access && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign key_wr = wr && hit(paddr, FRWL_UNLOCK_OFS);
  assign go_set = wr && hit(paddr, FRWL_CONTROL_OFS) && pwdata[FRWL_CTL_GO_BIT] && write_enable_bit_r && !busy;
  assign other_wr = wr && !hit(paddr, FRWL_UNLOCK_OFS) && !hit(paddr, FRWL_CONTROL_OFS);

  // R18 14-bit word
  assign lat_word = {dat_hi_r[5:0], dat_lo_r};

  frwl_unlock u_unlock (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .key_wr_i   (key_wr),
    .key_data_i (pwdata[7:0]),
    .other_wr_i (other_wr),
    .go_set_i   (go_set),
    .armed_o    (armed)
  );

  // R09 R10 load on armed go unless the go write sets the free or config select bit
  // Mode bits come from the go write itself, not the stale register
  assign lat_load = armed && !pwdata[FRWL_CTL_CONFIG_SPACE_SELECT_BIT] && !pwdata[FRWL_CTL_FREE_BIT];

  frwl_latch_bank #(
    .WORD_W  (WORD_W),
    .LATCHES (FRWL_LATCHES),
    .AW      (LATCH_AW)
  ) u_latches (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .load_i      (lat_load),
    .load_idx_i  (adr_lo_r[LATCH_AW-1:0]),
    .load_data_i (lat_word),
    .clear_i     (lat_clear),
    .rd_idx_i    (idx_r),
    .rd_data_o   (lat_q)
  );

  // Register file
  always_comb
  begin
    adr_lo_nxt = adr_lo_r;
    adr_hi_nxt = adr_hi_r;
    dat_lo_nxt = dat_lo_r;
    dat_hi_nxt = dat_hi_r;
    write_enable_bit_nxt   = write_enable_bit_r;
    config_space_select_nxt   = config_space_select_r;
    latch_only_select_nxt   = latch_only_select_r;
    free_nxt   = free_r;
    err_nxt    = err_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata;
    // No wait cycles: answer in the cycle after setup
    if (psel && !penable)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = !(hit(paddr, FRWL_ADDR_LOW_OFS) || hit(paddr, FRWL_ADDR_HIGH_OFS) ||
                      hit(paddr, FRWL_DATA_LOW_OFS) || hit(paddr, FRWL_DATA_HIGH_OFS) ||
                      hit(paddr, FRWL_CONTROL_OFS) || hit(paddr, FRWL_UNLOCK_OFS) ||
                      hit(paddr, FRWL_STATUS_OFS));
    end
    if (rd)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        FRWL_ADDR_LOW_OFS:  prdata_nxt[7:0] = adr_lo_r;
        FRWL_ADDR_HIGH_OFS: prdata_nxt[7:0] = {1'b0, adr_hi_r[6:0]};
        FRWL_DATA_LOW_OFS:  prdata_nxt[7:0] = dat_lo_r;
        FRWL_DATA_HIGH_OFS: prdata_nxt[7:0] = {2'b00, dat_hi_r[5:0]};
        FRWL_CONTROL_OFS:
        begin
          prdata_nxt[FRWL_CTL_GO_BIT]   = busy;
          prdata_nxt[FRWL_CTL_WRITE_ENABLE_BIT_BIT] = write_enable_bit_r;
          prdata_nxt[FRWL_CTL_ERR_BIT]  = err_r;
          prdata_nxt[FRWL_CTL_FREE_BIT] = free_r;
          prdata_nxt[FRWL_CTL_LATCH_ONLY_SELECT_BIT] = latch_only_select_r;
          prdata_nxt[FRWL_CTL_CONFIG_SPACE_SELECT_BIT] = config_space_select_r;
        end
        FRWL_STATUS_OFS:    prdata_nxt[7:0] = {5'b0_0000, st_r};
        default:            prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr && !busy)
    begin
      unique case (paddr)
        FRWL_ADDR_LOW_OFS:  adr_lo_nxt = pwdata[7:0];
        FRWL_ADDR_HIGH_OFS: adr_hi_nxt = {1'b0, pwdata[6:0]};
        FRWL_DATA_LOW_OFS:  dat_lo_nxt = pwdata[7:0];
        FRWL_DATA_HIGH_OFS: dat_hi_nxt = {2'b00, pwdata[5:0]};
        FRWL_CONTROL_OFS:
        begin
          write_enable_bit_nxt = pwdata[FRWL_CTL_WRITE_ENABLE_BIT_BIT];
          config_space_select_nxt = pwdata[FRWL_CTL_CONFIG_SPACE_SELECT_BIT];
          latch_only_select_nxt = pwdata[FRWL_CTL_LATCH_ONLY_SELECT_BIT];
          free_nxt = pwdata[FRWL_CTL_FREE_BIT];
          if (!pwdata[FRWL_CTL_ERR_BIT])
            err_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // Go without a valid unlock flags an error; set wins over clear
    if (go_set && !armed)
      err_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      adr_lo_r <= 8'h00;
      adr_hi_r <= 8'h00;
      dat_lo_r <= 8'h00;
      dat_hi_r <= 8'h00;
      write_enable_bit_r   <= 1'b0;
      config_space_select_r   <= 1'b0;
      latch_only_select_r   <= 1'b0;
      free_r   <= 1'b0;
      err_r    <= 1'b0;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      adr_lo_r <= adr_lo_nxt;
      adr_hi_r <= adr_hi_nxt;
      dat_lo_r <= dat_lo_nxt;
      dat_hi_r <= dat_hi_nxt;
      write_enable_bit_r   <= write_enable_bit_nxt;
      config_space_select_r   <= config_space_select_nxt;
      latch_only_select_r   <= latch_only_select_nxt;
      free_r   <= free_nxt;
      err_r    <= err_nxt;
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
    end
  end

  // Sequencer
  assign lat_clear = (st_r == FRWL_CLEAR);

  always_comb
  begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    idx_nxt      = idx_r;
    stall_nxt    = stall_r;
    prog_nxt     = 1'b0;
    erase_nxt    = 1'b0;
    aaddr_nxt    = aaddr_r;
    awd_nxt      = awd_r;
    op_erase_nxt = op_erase_r;
    unique case (st_r)
      FRWL_IDLE:
      begin
        if (armed)
        begin
          // R15 two forced idle cycles
          st_nxt       = FRWL_NOPS;
          cnt_nxt      = 32'(FRWL_NOP_CYCLES - 1);
          stall_nxt    = 1'b1;
          op_erase_nxt = pwdata[FRWL_CTL_FREE_BIT];
        end
      end
      FRWL_NOPS:
      begin
        if (cnt_r == 32'h0000_0000)
        begin
          // R09 latch-only ends here
          if (latch_only_select_r && !op_erase_r)
          begin
            st_nxt    = FRWL_IDLE;
            stall_nxt = 1'b0;
          end
          else
          begin
            // R16 stall through array time
            st_nxt  = FRWL_ARRAY;
            cnt_nxt = 32'(PROG_CYCLES - 1);
            idx_nxt = '0;
          end
        end
        else
          cnt_nxt = cnt_r - 32'h0000_0001;
      end
      FRWL_ARRAY:
      begin
        // R05 R06 row fixed, column walks only latch index
        aaddr_nxt = {adr_hi_r[6:0], adr_lo_r[7:LATCH_AW], idx_r};
        awd_nxt   = lat_q;
        if (op_erase_r)
        begin
          // R03 single row erase
          erase_nxt = (cnt_r == 32'(PROG_CYCLES - 1));
          aaddr_nxt = {adr_hi_r[6:0], adr_lo_r[7:LATCH_AW], {LATCH_AW{1'b0}}};
        end
        else if (cnt_r > 32'(PROG_CYCLES - 1 - FRWL_LATCHES))
        begin
          // R02 R04 at most sixteen programs, blank words skipped by sequencer
          prog_nxt = (lat_q != WORD_W'(FRWL_BLANK));
          idx_nxt  = idx_r + LATCH_AW'(1);
        end
        if (cnt_r == 32'h0000_0000)
          st_nxt = FRWL_CLEAR;
        else
          cnt_nxt = cnt_r - 32'h0000_0001;
      end
      FRWL_CLEAR:
      begin
        // R07 reset latches
        st_nxt    = FRWL_IDLE;
        stall_nxt = 1'b0;
      end
      default:
      begin
        st_nxt    = FRWL_IDLE;
        stall_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r       <= FRWL_IDLE;
      cnt_r      <= 32'h0000_0000;
      idx_r      <= '0;
      stall_r    <= 1'b0;
      prog_r     <= 1'b0;
      erase_r    <= 1'b0;
      aaddr_r    <= '0;
      awd_r      <= '0;
      op_erase_r <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      idx_r      <= idx_nxt;
      stall_r    <= stall_nxt;
      prog_r     <= prog_nxt;
      erase_r    <= erase_nxt;
      aaddr_r    <= aaddr_nxt;
      awd_r      <= awd_nxt;
      op_erase_r <= op_erase_nxt;
    end
  end

  assign core_stall_o = stall_r;
  assign arr_prog_o   = prog_r;
  assign arr_erase_o  = erase_r;
  assign arr_addr_o   = aaddr_r;
  assign arr_wdata_o  = awd_r;
endmodule

// >>> design/frwl_unlock.sv
`timescale 1ns/1ns
module frwl_unlock
  import frwl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Register write events
  input  wire logic       key_wr_i,
  input  wire logic [7:0] key_data_i,
  input  wire logic       other_wr_i,
  input  wire logic       go_set_i,
  // Result
  output logic            armed_o
);
  logic [1:0] stage_r;
  logic [1:0] stage_nxt;

  // R14 key order
  // R11 a go, or a write to a register other than key or control, breaks it
  always_comb
  begin
    stage_nxt = stage_r;
    if (key_wr_i)
    begin
      if (stage_r == 2'h0 && key_data_i == FRWL_KEY_FIRST)
        stage_nxt = 2'h1;
      else if (stage_r == 2'h1 && key_data_i == FRWL_KEY_SECOND)
        stage_nxt = 2'h2;
      else if (key_data_i == FRWL_KEY_FIRST)
        stage_nxt = 2'h1;
      else
        stage_nxt = 2'h0;
    end
    else if (other_wr_i || go_set_i)
      stage_nxt = 2'h0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      stage_r <= 2'h0;
    else
      stage_r <= stage_nxt;
  end

  assign armed_o = go_set_i && stage_r == 2'h2;
endmodule

// >>> verification/frwl_flash_model.sv
`timescale 1ns/1ns
module frwl_flash_model
  import frwl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Array port
  input  wire logic        arr_prog_i,
  input  wire logic        arr_erase_i,
  input  wire logic [14:0] arr_addr_i,
  input  wire logic [13:0] arr_wdata_i,
  output logic      [13:0] arr_rdata_o,
  // Bench view
  input  wire logic [14:0] peek_addr_i,
  output logic      [13:0] peek_data_o,
  output logic      [7:0]  prog_cnt_o,
  output logic      [7:0]  erase_cnt_o
);
  logic [13:0] mem [logic [14:0]];
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prog_cnt_o  <= 8'h00;
      erase_cnt_o <= 8'h00;
      arr_rdata_o <= 14'h0000;
    end
    else
    begin
      // Unused read path never holds a value
      arr_rdata_o <= ~arr_rdata_o;
      if (arr_prog_i)
      begin
        mem[arr_addr_i] = (mem.exists(arr_addr_i) ? mem[arr_addr_i] : FRWL_BLANK) & arr_wdata_i;
        prog_cnt_o <= prog_cnt_o + 8'h01;
      end
      if (arr_erase_i)
      begin
        for (int i = 0; i < 16; i++)
          mem[{arr_addr_i[14:4], i[3:0]}] = FRWL_BLANK;
        erase_cnt_o <= erase_cnt_o + 8'h01;
      end
      peek_data_o <= mem.exists(peek_addr_i) ? mem[peek_addr_i] : FRWL_BLANK;
    end
  end
endmodule

// >>> verification/frwl_top_sva.sv
`timescale 1ns/1ns
module frwl_top_sva
  import frwl_pkg::*;
#(
  parameter int PROG_CYCLES = FRWL_PROG_CYCLES
)
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Core and array side
  input wire logic        core_stall_o,
  input wire logic        arr_prog_o,
  input wire logic        arr_erase_o,
  input wire logic [14:0] arr_addr_o,
  input wire logic [13:0] arr_wdata_o
);
  logic [7:0]  prog_n_r;
  logic [7:0]  prog_n_nxt;
  logic [31:0] stall_n_r;
  logic [31:0] stall_n_nxt;
  wire  [10:0] row_w = arr_addr_o[14:4];
  wire  [3:0]  idx_w = arr_addr_o[3:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Counts restart whenever the core runs again
  always_comb
  begin
    prog_n_nxt  = core_stall_o ? prog_n_r + 8'(arr_prog_o) : 8'h00;
    stall_n_nxt = core_stall_o ? stall_n_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prog_n_r  <= 8'h00;
      stall_n_r <= 32'h0000_0000;
    end
    else
    begin
      prog_n_r  <= prog_n_nxt;
      stall_n_r <= stall_n_nxt;
    end
  end
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no ready after setup");
  property p_nop_min;
    $rose(core_stall_o) |-> core_stall_o [*2];
  endproperty
  a_nop_min: assert property (p_nop_min)
    else $error("stall shorter than two cycles");
  property p_prog_after_nops;
    arr_prog_o |-> $past(core_stall_o, 2) && core_stall_o;
  endproperty
  a_prog_after_nops: assert property (p_prog_after_nops)
    else $error("program outside stalled operation");
  property p_erase_in_op;
    arr_erase_o |-> core_stall_o && !arr_prog_o;
  endproperty
  a_erase_in_op: assert property (p_erase_in_op)
    else $error("erase outside operation");
  property p_no_blank_prog;
    arr_prog_o |-> arr_wdata_o != FRWL_BLANK;
  endproperty
  a_no_blank_prog: assert property (p_no_blank_prog)
    else $error("blank word programmed");
  property p_row_hold;
    arr_prog_o && $past(arr_prog_o) |-> row_w == $past(row_w);
  endproperty
  a_row_hold: assert property (p_row_hold)
    else $error("row changed within one write");
  property p_idx_step;
    arr_prog_o && $past(arr_prog_o) |-> idx_w == $past(idx_w) + 4'h1;
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("latch index out of order");
  property p_prog_count;
    arr_prog_o |-> prog_n_r < 8'd16;
  endproperty
  a_prog_count: assert property (p_prog_count)
    else $error("more than sixteen words in one write");
  property p_stall_bound;
    stall_n_r <= 32'(PROG_CYCLES + 4);
  endproperty
  a_stall_bound: assert property (p_stall_bound)
    else $error("stall too long");
endmodule
bind frwl_top frwl_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pready(pready),
  .core_stall_o(core_stall_o), .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o),
  .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o)
);

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import frwl_pkg::*;
;
  localparam int PROG = 40;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, core_stall_o, arr_prog_o, arr_erase_o;
  logic [14:0] arr_addr_o, peek_addr = 15'h0000;
  logic [13:0] arr_wdata_o, arr_rdata_i, peek_data;
  logic [7:0]  prog_cnt, erase_cnt;
  int          mismatches = 0, comparisons = 0, cycles = 0, stall_n;
  always #5 clk_i = ~clk_i;
  frwl_top #(.PROG_CYCLES(PROG)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_stall_o(core_stall_o), .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o),
    .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o), .arr_rdata_i(arr_rdata_i)
  );
  frwl_flash_model u_flash (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .arr_prog_i(arr_prog_o), .arr_erase_i(arr_erase_o),
    .arr_addr_i(arr_addr_o), .arr_wdata_i(arr_wdata_o), .arr_rdata_o(arr_rdata_i),
    .peek_addr_i(peek_addr), .peek_data_o(peek_data), .prog_cnt_o(prog_cnt), .erase_cnt_o(erase_cnt)
  );
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Waits for pready; only the bench timeout ends a wait that never sees it
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Stall length counted in whole cycles
  task automatic go(input logic [31:0] ctl);
    wr(FRWL_UNLOCK_OFS, 32'h0000_0055);
    wr(FRWL_UNLOCK_OFS, 32'h0000_00AA);
    wr(FRWL_CONTROL_OFS, ctl | 32'h0000_0006);
    stall_n = 0;
    @(posedge clk_i);
    while (core_stall_o === 1'b1)
    begin
      stall_n++;
      @(posedge clk_i);
    end
  endtask
  task automatic lat(input int i, input logic [31:0] ctl);
    wr(FRWL_ADDR_LOW_OFS, 32'h0000_0090 | i);
    wr(FRWL_DATA_HIGH_OFS, 32'h0000_00C0 | i);
    wr(FRWL_DATA_LOW_OFS, 32'h0000_00A0 | i);
    go(ctl);
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped_err", err, 1);
    wr(FRWL_ADDR_HIGH_OFS, 32'h0000_0045);
    wr(FRWL_ADDR_LOW_OFS, 32'h0000_0097);
    wr(FRWL_DATA_HIGH_OFS, 32'h0000_00C7);
    wr(FRWL_CONTROL_OFS, 32'h0000_0024);
    // A stray write between keys, then broken key order
    for (int c = 0; c < 2; c++)
    begin
      wr(FRWL_UNLOCK_OFS, c ? 32'h0000_00AA : 32'h0000_0055);
      if (c == 0)
        wr(FRWL_DATA_LOW_OFS, 32'h0000_0011);
      wr(FRWL_UNLOCK_OFS, c ? 32'h0000_0055 : 32'h0000_00AA);
      wr(FRWL_CONTROL_OFS, 32'h0000_0026);
      @(posedge clk_i);
      chk("broken_stall", core_stall_o, 0);
      apb(1'b0, FRWL_CONTROL_OFS, 32'h0000_0000);
      chk("err_bit", rd[FRWL_CTL_ERR_BIT], 1);
      wr(FRWL_CONTROL_OFS, 32'h0000_0024);
    end
    for (int i = 3; i < 6; i++)
    begin
      lat(i, i < 5 ? 32'h0000_0020 : 32'h0000_0000);
      if (i < 5)
        chk("nop_stall", stall_n, 2);
      chk("prog_count", prog_cnt, i < 5 ? 0 : 3);
    end
    chk("prog_stall", stall_n >= PROG, 1);
    for (int i = 0; i < 16; i++)
    begin
      logic [13:0] exp;
      exp = (i >= 3 && i <= 5) ? {i[5:0], 8'hA0 | i[7:0]} : FRWL_BLANK;
      peek_addr <= {11'h459, i[3:0]};
      repeat (2) @(posedge clk_i);
      chk("word", peek_data, exp);
    end
    lat(0, 32'h0000_0000);
    chk("single_prog", prog_cnt, 4);
    go(32'h0000_0010);
    chk("erase_count", erase_cnt, 1);
    chk("erase_no_prog", prog_cnt, 4);
    peek_addr <= {11'h459, 4'h3};
    repeat (2) @(posedge clk_i);
    chk("erased_word", peek_data, FRWL_BLANK);
    print_verdict;
  end
endmodule
